// [hdl/rdt_debounce.sv]
`timescale 1ns/100ps
module rdt_debounce
  import rdt_pkg::*;
#(
  parameter int WIDTH = RDT_BUTTON_COUNT,
  parameter int TICKS = RDT_DEBOUNCE_TICKS
)
(
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  // Oscillator period pulse and raw inputs
  input  wire logic             i_tick,
  input  wire logic [WIDTH-1:0] i_raw,
  // Filtered inputs
  output logic      [WIDTH-1:0] o_stable_q
);

  localparam int CW = $clog2(TICKS + 1);
  localparam logic [CW-1:0] LAST_TICK = CW'(TICKS - 1);
  localparam logic [CW-1:0] CNT_ZERO  = '0;

  logic [WIDTH-1:0] sample_q;  // Last raw value seen
  logic [CW-1:0]    cnt_q;     // Stable periods so far
  logic [CW-1:0]    cnt_d;
  logic             moved;     // Raw value differs from sample
  logic             accept;    // Sample held long enough

  // Any change on either edge restarts the interval
  assign moved  = (i_raw != sample_q);
  assign accept = !moved && i_tick && (cnt_q == LAST_TICK);
  assign cnt_d  = moved ? CNT_ZERO : ((i_tick && cnt_q != CW'(TICKS)) ? cnt_q + CW'(1) : cnt_q);

  // Shared counter for all inputs together
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      sample_q   <= '0;
      cnt_q      <= '0;
      o_stable_q <= '0;
    end
    else
    begin
      sample_q <= i_raw;
      cnt_q    <= cnt_d;
      if (accept)
        o_stable_q <= sample_q;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  // Filtered value moves only after a full stable interval
  a_debounce_stable: assert property ($changed(o_stable_q) |-> $past(cnt_q) == LAST_TICK)
    else $error("debounced input changed before interval elapsed");

endmodule

// [hdl/rdt_pkg.sv]
package rdt_pkg;

  // Debounce interval in oscillator periods
  localparam int RDT_DEBOUNCE_TICKS = 6;
  // Automatic switch-off delay in oscillator periods
  localparam int RDT_DELAY_TICKS    = 73728;
  // Number of push-button inputs sharing the debounce stage
  localparam int RDT_BUTTON_COUNT   = 3;

  // Push-button inputs travel together
  typedef struct packed {
    logic switch_on;   // Switch-on button
    logic switch_off;  // Switch-off button
    logic toggle;      // Toggle button
  } rdt_buttons_t;

  // Relay time function state
  typedef enum logic [0:0] {
    RDT_IDLE   = 1'h0,
    RDT_ACTIVE = 1'h1
  } rdt_state_t;

endpackage

// [hdl/rdt_relay_timer.sv]
`timescale 1ns/100ps
// Summary of operation
// - Reset leaves relay output inactive
// - First toggle press activates after debounce
// - Each toggle press inverts relay output
// - Toggle mode output expires after delay
// - Switch-on press activates after debounce
// - Switch-off press deactivates relay output
// - On/off mode output expires after delay
// - Debounce filters both edges of inputs
// - One shared debounce, one scheme used
// - Held switch-on still expires, no retrigger
// - Debounce six periods, delay 73728 periods
module rdt_relay_timer
  import rdt_pkg::*;
#(
  parameter int DEBOUNCE_TICKS = RDT_DEBOUNCE_TICKS,
  parameter int DELAY_TICKS    = RDT_DELAY_TICKS
)
(
  // Clock and reset
  input  wire logic   i_clock,
  input  wire logic   i_sys_rst,
  // Oscillator timebase and scheme select
  input  wire logic   i_rc_timebase_input,
  input  wire logic   i_toggle_mode,
  // Push buttons
  input  rdt_buttons_t i_buttons,
  // Relay drive
  output logic        o_relay_active
);

  localparam int DW = $clog2(DELAY_TICKS + 1);
  localparam logic [DW-1:0] DELAY_LAST = DW'(DELAY_TICKS - 1);
  localparam logic [DW-1:0] DELAY_ZERO = '0;
  localparam logic [DW-1:0] DELAY_FULL = DW'(DELAY_TICKS);

  logic            osc_q;       // Previous timebase level
  logic            tick;        // One pulse per oscillator period
  rdt_buttons_t    level;       // Debounced button levels
  rdt_buttons_t    level_q;     // Levels one clock earlier
  rdt_buttons_t    press;       // Debounced closing edges
  rdt_state_t      state_q;     // Time function state
  rdt_state_t      state_d;
  logic [DW-1:0]   cnt_q;       // Elapsed oscillator periods
  logic [DW-1:0]   cnt_d;
  logic            toggle_ev;   // Toggle press in toggle scheme
  logic            on_ev;       // Switch-on press in on/off scheme
  logic            off_ev;      // Switch-off held in on/off scheme
  logic            expire;      // Delay interval complete
  // Check-only helper state
  logic [DW-1:0]   chk_ticks_q; // Periods seen with relay on
  logic [DW-1:0]   chk_ticks_d;

  // Rising edge of the timebase marks one period
  assign tick = i_rc_timebase_input && !osc_q;

  // All three buttons share one filter
  rdt_debounce #(
    .WIDTH (RDT_BUTTON_COUNT),
    .TICKS (DEBOUNCE_TICKS)
  ) u_debounce (
    .i_clock    (i_clock),
    .i_sys_rst  (i_sys_rst),
    .i_tick     (tick),
    .i_raw      (i_buttons),
    .o_stable_q (level)
  );

  // Event decode, only the selected scheme is heard
  assign press     = level & ~level_q;
  assign toggle_ev = i_toggle_mode && press.toggle;
  assign on_ev     = !i_toggle_mode && press.switch_on && !level.switch_off;
  assign off_ev    = !i_toggle_mode && level.switch_off;
  assign expire    = (state_q == RDT_ACTIVE) && tick && (cnt_q == DELAY_LAST);

  // Next state of the time function
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      RDT_IDLE:
      begin
        // Start on a fresh press only; held levels do nothing
        if (toggle_ev || on_ev)
          state_d = RDT_ACTIVE;
      end
      RDT_ACTIVE:
      begin
        // Any stop cause ends the function
        if (toggle_ev || off_ev || expire)
          state_d = RDT_IDLE;
      end
    endcase
  end

  // Counter cleared at start and at stop
  assign cnt_d = (state_q == RDT_IDLE || state_d == RDT_IDLE) ? DELAY_ZERO
               : (tick ? cnt_q + DW'(1) : cnt_q);

  // State, counter and output registers
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      osc_q          <= 1'h0;
      level_q        <= '0;
      state_q        <= RDT_IDLE;
      cnt_q          <= '0;
      o_relay_active <= 1'h0;
    end
    else
    begin
      osc_q          <= i_rc_timebase_input;
      level_q        <= level;
      state_q        <= state_d;
      cnt_q          <= cnt_d;
      o_relay_active <= (state_d == RDT_ACTIVE);
    end
  end

  // Check-only tally of periods while the relay is driven
  // Kept apart from the delay counter so a fault there shows
  assign chk_ticks_d = !o_relay_active ? DELAY_ZERO
                     : (tick ? chk_ticks_q + DW'(1) : chk_ticks_q);

  // Tally register, read by the checks below only
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      chk_ticks_q <= '0;
    else
      chk_ticks_q <= chk_ticks_d;
  end

  // Checks below share the system clock and reset
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  // Toggle press seen with the relay off
  sequence s_idle_toggle;
    !o_relay_active && toggle_ev;
  endsequence
  // Toggle press seen with the relay driven
  sequence s_active_toggle;
    o_relay_active && toggle_ev;
  endsequence

  a_reset_relay_off: assert property (disable iff (1'b0) i_sys_rst |=> !o_relay_active)
    else $error("relay not inactive after reset");
  a_toggle_start: assert property (s_idle_toggle |=> o_relay_active ##1 cnt_q <= DW'(1))
    else $error("toggle press did not start relay");
  a_toggle_invert: assert property (s_active_toggle |=> !o_relay_active)
    else $error("toggle press did not stop relay");
  a_delay_expire: assert property (expire && !toggle_ev |=> !o_relay_active && cnt_q == DELAY_ZERO)
    else $error("relay did not stop at end of delay");
  a_on_start: assert property (!o_relay_active && on_ev |=> o_relay_active)
    else $error("switch-on press did not start relay");
  a_off_stop: assert property (off_ev |=> !o_relay_active)
    else $error("switch-off did not keep relay inactive");
  a_no_retrigger: assert property (!i_toggle_mode && !o_relay_active && !press.switch_on |=> !o_relay_active)
    else $error("relay started without a fresh press");
  a_count_restart: assert property ($rose(o_relay_active) |-> cnt_q == DELAY_ZERO)
    else $error("delay count not restarted on activation");
  a_no_early_stop: assert property (o_relay_active && !toggle_ev && !off_ev && cnt_q != DELAY_LAST
                                    |=> o_relay_active)
    else $error("relay stopped before delay elapsed");

  // Fresh on/off press from idle with nothing opposing it
  sequence s_idle_on_press;
    !i_toggle_mode && !o_relay_active && press.switch_on && !level.switch_off;
  endsequence
  // Relay driven with the delay count back at zero
  sequence s_fresh_start;
    o_relay_active && cnt_q == DELAY_ZERO;
  endsequence
  // Switch-off level held while the on/off scheme is in use
  sequence s_off_held;
    !i_toggle_mode && level.switch_off;
  endsequence

  // Checks on the two input schemes
  // Start from a switch-on press always begins a full interval
  a_on_fresh_start: assert property (s_idle_on_press |=> s_fresh_start)
    else $error("switch-on start did not clear the delay count");
  // Off held over two cycles leaves the relay off
  a_off_holds_low: assert property (s_off_held ##1 s_off_held |-> !o_relay_active)
    else $error("relay active while switch-off held");
  // Toggle scheme ignores the on/off buttons
  a_mode_on_ignored: assert property (i_toggle_mode && !o_relay_active && !press.toggle
                                      |=> !o_relay_active)
    else $error("relay started by a button of the other scheme");
  // On/off scheme ignores toggle presses while the relay is on
  a_scheme_isolation: assert property (!i_toggle_mode && o_relay_active && !off_ev && !expire
                                       |=> o_relay_active)
    else $error("relay stopped by a button of the other scheme");

  // Checks on the delay count
  // Delay count rests at zero whenever the relay is off
  a_count_idle_zero: assert property (!o_relay_active |-> cnt_q == DELAY_ZERO)
    else $error("delay count not cleared while relay off");
  // Delay count never passes its last period
  a_count_bounded: assert property (cnt_q <= DELAY_LAST)
    else $error("delay count beyond its last period");
  // While running, the count moves by one per period only
  a_count_steps: assert property (o_relay_active && !toggle_ev && !off_ev && !expire
                                  |=> cnt_q == $past(cnt_q) + DW'($past(tick)))
    else $error("delay count moved without a period");
  // Independent tally never runs past the full delay
  a_tally_limit: assert property (chk_ticks_q <= DELAY_FULL)
    else $error("relay held beyond the delay interval");
  // Full delay counted means the relay has dropped
  a_tally_stop: assert property (chk_ticks_q == DELAY_FULL |-> !o_relay_active)
    else $error("relay still active after the delay interval");

  // Checks on the timebase
  // Timebase edge detector gives single-clock pulses
  a_tick_single: assert property (tick |=> !tick)
    else $error("period pulse lasted more than one clock");

endmodule

// [verification/rdt_partner.sv]
`timescale 1ns/100ps
module rdt_partner
  import rdt_pkg::*;
(
  // Clock
  input  wire logic    i_clock,
  // Commanded presses and contact chatter
  input  rdt_buttons_t i_press,
  input  wire logic    i_chatter,
  // Pin levels seen by the device
  output rdt_buttons_t o_buttons,
  output logic         o_timebase
);
  logic [3:0] div_q = 4'h0;  // RC oscillator divider

  // Free-running timebase, 8 clocks per period
  always @(posedge i_clock)
  begin
    div_q <= #1 div_q + 4'h1;
  end

  assign o_timebase = div_q[2];
  // Open contacts fall to the pull-down level
  // Chatter flips twice a period, far shorter than debounce
  // On and off together only when the bench commands it
  assign o_buttons = i_press & {3{~i_chatter | div_q[2]}};
endmodule

// [verification/relay_delay_timer_test.sv]
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module relay_delay_timer_test;
  import rdt_pkg::*;
  localparam int DLY = 20;  // Shortened delay in ticks
  // One ordinary case: scheme, buttons, relay level after settling
  typedef struct packed {logic mode; rdt_buttons_t btn; logic exp;} rdt_row_t;
  logic         clock   = 1'b0;  // System clock
  logic         rst     = 1'b1;  // Synchronous reset
  logic         mode    = 1'b1;  // Scheme select
  logic         chatter = 1'b0;  // Contact chatter enable
  logic         tb_q    = 1'b0;  // Previous timebase level
  rdt_buttons_t press   = '0;    // Commanded presses
  rdt_buttons_t buttons;         // Pin levels
  logic         timebase;        // Oscillator wave
  logic         relay;           // Relay drive
  int           errors = 0, compares = 0, cycles = 0, ticks = 0;
  rdt_row_t rows [11] = '{'{1'b1, 3'h1, 1'b1}, '{1'b1, 3'h0, 1'b1}, '{1'b1, 3'h1, 1'b0}, '{1'b1, 3'h0, 1'b0},
    '{1'b1, 3'h4, 1'b0}, '{1'b0, 3'h0, 1'b0}, '{1'b0, 3'h4, 1'b1}, '{1'b0, 3'h6, 1'b0}, '{1'b0, 3'h4, 1'b0},
    '{1'b0, 3'h0, 1'b0}, '{1'b0, 3'h6, 1'b0}};

  always #2.5 clock = ~clock;

  rdt_partner rdt_partner_i (.i_clock(clock), .i_press(press), .i_chatter(chatter), .o_buttons(buttons),
    .o_timebase(timebase));
  rdt_relay_timer #(.DELAY_TICKS(DLY)) rdt_relay_timer_i (.i_clock(clock), .i_sys_rst(rst),
    .i_rc_timebase_input(timebase), .i_toggle_mode(mode), .i_buttons(buttons), .o_relay_active(relay));

  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic end_sim;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Ticks seen while the relay is on; hang guard
  always @(posedge clock)
  begin
    if (relay === 1'b1 && timebase === 1'b1 && tb_q === 1'b0)
      ticks++;
    tb_q = timebase;
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_sim;
    end
  end

  // Held press: relay must drop on its own after the delay
  task automatic expire(input logic m, input rdt_buttons_t b);
    mode  = m;
    press = b;
    for (int w = 0; w < 100 && relay !== 1'b1; w++)
      step(1);
    ticks = 0;
    for (int w = 0; w < 300 && relay === 1'b1; w++)
      step(1);
    `CHK("delay ticks", DLY, ticks)
    press = '0;
    step(64);
  endtask

  initial
  begin
    repeat (10) @(posedge clock);
    #1;
    `CHK("relay in reset", 1'b0, relay)
    rst = 1'b0;
    // First press only a cycle after release
    step(1);
    `CHK("relay after release", 1'b0, relay)
    foreach (rows[i])
    begin
      mode  = rows[i].mode;
      press = rows[i].btn;
      step(64);
      `CHK("relay row", rows[i].exp, relay)
    end
    expire(1'b1, 3'h1);
    expire(1'b0, 3'h4);
    // Chatter never settles, relay stays off
    mode    = 1'b1;
    chatter = 1'b1;
    press   = 3'h1;
    step(200);
    `CHK("relay chatter", 1'b0, relay)
    press   = '0;
    chatter = 1'b0;
    step(64);
    // Reset in mid-run drops an active relay
    press = 3'h1;
    step(64);
    `CHK("relay before reset", 1'b1, relay)
    rst = 1'b1;
    step(2);
    `CHK("relay mid reset", 1'b0, relay)
    // Release with toggle still held: filter restarts from zero
    rst = 1'b0;
    step(2);
    `CHK("relay second release", 1'b0, relay)
    step(62);
    `CHK("relay held toggle", 1'b1, relay)
    end_sim;
  end
endmodule
